// ---- inc/cq_pkg.sv ----
package cq_pkg;
    // Register offsets within the five-bit register field
    localparam logic [4:0] ADDR_LED  = 5'h0e;
    localparam logic [4:0] ADDR_TRIG = 5'h0f;
    localparam logic [4:0] ADDR_CFG  = 5'h10;
    // Reset values
    localparam logic [7:0] RST_LED  = 8'h00;
    localparam logic [3:0] RST_TRIG = 4'h0;
    localparam logic [7:0] RST_CFG  = 8'h00;
    // Pin function and LED bit positions
    localparam int LED_RDY_SEL_A = 0;
    localparam int LED_LED1_A    = 1;
    localparam int LED_ERR_SEL_A = 2;
    localparam int LED_LED2_A    = 3;
    // Line configuration bit positions
    localparam int CFG_FILT    = 0;
    localparam int CFG_DRV_OFF = 1;
    localparam int CFG_PP      = 2;
    localparam int CFG_NPN     = 3;
    localparam int CFG_LVL_LO  = 4;
    localparam int CFG_DIR     = 6;
    localparam int CFG_THR     = 7;
    // Current level code for element off
    localparam logic [1:0] LVL_OFF = 2'h0;
    // Trigger field width
    localparam int TRIG_W = 4;
    // Command byte layout: read flag, two select bits, register address
    localparam int CMD_RD  = 7;
    localparam int CMD_SHI = 6;
    localparam int CMD_SLO = 5;
    // Frame length in serial clocks
    localparam logic [4:0] CNT_CMD_LAST = 5'h07;
    localparam logic [4:0] CNT_LAST     = 5'h0f;
    localparam logic [4:0] CNT_DONE     = 5'h10;
    // Burst filter time and its cycle count
    localparam int CLK_PERIOD_PS = 4000;
    localparam int FILT_NS       = 1300;
    localparam int FILT_CYC      = (FILT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage : cq_pkg

// ---- src/cq_chan_cfg.sv ----
`timescale 1ns/1ps
// Functional notes
// - Error pin select 1: error/LED2 pin follows receive error flag.
// - In error indication mode the receive error mask has no effect.
// - Error pin select 0: error/LED2 pin works as LED driver.
// - LED2 control acts only while the pin is in LED mode.
// - LED1 control lights ready/LED1 pin, only while ready select is 0.
// - Ready select 1: ready/LED1 pin follows receive data ready flag.
// - Ready indication ignores data ready mask; select 0 gives LED driver.
// - Trigger write matching a channel value starts timer and master message.
// - Trigger writes are taken whatever the device select bits say.
// - Trigger upper four bits unused; lower four write-only, reset zero.
// - Cycle timer starts on a match only when its enable is set.
// - Threshold select: 0 type 1 thresholds, 1 type 2/3 thresholds.
// - Direction bit: 1 current source, 0 current sink.
// - Level code 00 off, 01 5mA, 10 2mA, 11 150uA.
// - Polarity 1 NPN, 0 PNP, ignored in push-pull mode.
// - Push-pull bit 1 push-pull driver, 0 open-drain driver.
// - Driver off bit 1 puts line driver in high impedance.
// - Filter bit enables burst filter on the line receiver.
// - Line configuration fully read/write, resets zero, not cleared on read.
module cq_chan_cfg (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Serial register port
    input  wire logic       spi_sclk,
    input  wire logic       spi_cs_b,
    input  wire logic       spi_mosi,
    output logic            spi_miso,
    input  wire logic [1:0] dev_addr,
    // Framer side
    input  wire logic       receive_error_flag_a,
    input  wire logic       receive_data_ready_flag_a,
    input  wire logic       tx_data_a,
    input  wire logic [3:0] trigger_match_value_a,
    input  wire logic [3:0] trigger_match_value_b,
    input  wire logic       cycle_timer_on_a,
    input  wire logic       cycle_timer_on_b,
    output logic [3:0]      trigger_value,
    output logic            send_master_a,
    output logic            send_master_b,
    output logic            timer_start_a,
    output logic            timer_start_b,
    output logic            rx_data_a,
    // Indication pins
    output logic            error_led2_pin_a,
    output logic            ready_led1_pin_a,
    // Line pin and analog controls
    input  wire logic       line_pin_a_in,
    output logic            line_pin_a_out,
    output logic            line_pin_a_oe_b,
    output logic            threshold_type_select_a,
    output logic            current_direction_select_a,
    output logic [1:0]      current_level_select_a,
    output logic            current_on_a,
    output logic            receiver_burst_filter_on_a
);
    // Serial domain state
    logic       frame_rst_b;
    logic [4:0] bit_cnt;
    logic [14:0] sh;
    logic [7:0] rd_byte;
    logic [1:0] sel_s1;
    logic [1:0] sel_s2;
    logic [7:0] mir_led;
    logic [7:0] mir_cfg;
    logic [4:0] xw_addr;
    logic [7:0] xw_data;
    logic       xw_tgl;
    logic [15:0] next_word;
    logic       word_sel;
    logic       cmd_sel;
    // Core domain state
    logic       xs1;
    logic       xs2;
    logic       xs3;
    logic       wr_ev;
    logic [7:0] led_reg;
    logic [7:0] cfg_reg;
    logic       line_s1;
    logic       line_s2;
    logic [8:0] filt_cnt;

    // Whole word and select match at the last and the command edge
    assign next_word = {sh, spi_mosi};
    assign word_sel  = next_word[cq_pkg::CMD_SHI+8 -: 2] == sel_s2;
    assign cmd_sel   = next_word[cq_pkg::CMD_SHI:cq_pkg::CMD_SLO] == sel_s2;
    assign frame_rst_b = rst_b & ~spi_cs_b;

    // Bit counter and shifter, cleared when the frame ends
    always_ff @(posedge spi_sclk or negedge frame_rst_b) begin
        if (!frame_rst_b) begin
            bit_cnt <= 5'h00;
            sh      <= 15'h0000;
        end else begin
            sh <= next_word[14:0];
            if (bit_cnt != cq_pkg::CNT_DONE) begin
                bit_cnt <= bit_cnt + 5'h01;
            end
        end
    end

    // Read byte chosen once the command byte is in
    always_ff @(posedge spi_sclk or negedge frame_rst_b) begin
        if (!frame_rst_b) begin
            rd_byte <= 8'h00;
        end else if (bit_cnt == cq_pkg::CNT_CMD_LAST) begin
            rd_byte <= 8'h00;
            if (next_word[cq_pkg::CMD_RD] && cmd_sel) begin
                case (next_word[4:0])
                    cq_pkg::ADDR_LED: rd_byte <= mir_led;
                    cq_pkg::ADDR_CFG: rd_byte <= mir_cfg;
                    default:          rd_byte <= 8'h00;
                endcase
            end
        end
    end

    // Read data out on falling edges
    always_ff @(negedge spi_sclk or negedge rst_b) begin
        if (!rst_b) begin
            spi_miso <= 1'b0;
        end else if (bit_cnt[4:3] == 2'h1) begin
            spi_miso <= rd_byte[3'(cq_pkg::CNT_LAST - bit_cnt)];
        end else begin
            spi_miso <= 1'b0;
        end
    end

    // Select straps settle through two stages on the serial clock
    always_ff @(posedge spi_sclk or negedge rst_b) begin
        if (!rst_b) begin
            sel_s1 <= 2'h0;
            sel_s2 <= 2'h0;
        end else begin
            sel_s1 <= dev_addr;
            sel_s2 <= sel_s1;
        end
    end

    // Completed write: held word, toggle and readback copies
    always_ff @(posedge spi_sclk or negedge rst_b) begin
        if (!rst_b) begin
            xw_addr <= 5'h00;
            xw_data <= 8'h00;
            xw_tgl  <= 1'b0;
            mir_led <= cq_pkg::RST_LED;
            mir_cfg <= cq_pkg::RST_CFG;
        end else if (!spi_cs_b && bit_cnt == cq_pkg::CNT_LAST && !next_word[cq_pkg::CMD_RD + 8]) begin
            if (next_word[12:8] == cq_pkg::ADDR_TRIG || word_sel) begin
                xw_addr <= next_word[12:8];
                xw_data <= next_word[7:0];
                xw_tgl  <= ~xw_tgl;
            end
            if (word_sel && next_word[12:8] == cq_pkg::ADDR_LED) begin
                mir_led <= next_word[7:0];
            end
            if (word_sel && next_word[12:8] == cq_pkg::ADDR_CFG) begin
                mir_cfg <= next_word[7:0];
            end
        end
    end

    // Write toggle into the core clock
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            xs1 <= 1'b0;
            xs2 <= 1'b0;
            xs3 <= 1'b0;
        end else begin
            xs1 <= xw_tgl;
            xs2 <= xs1;
            xs3 <= xs2;
        end
    end
    assign wr_ev = xs2 ^ xs3;

    // Register bank, changed only by writes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            led_reg       <= cq_pkg::RST_LED;
            cfg_reg       <= cq_pkg::RST_CFG;
            trigger_value <= cq_pkg::RST_TRIG;
        end else if (wr_ev) begin
            case (xw_addr)
                cq_pkg::ADDR_LED:  led_reg       <= xw_data;
                cq_pkg::ADDR_CFG:  cfg_reg       <= xw_data;
                cq_pkg::ADDR_TRIG: trigger_value <= xw_data[cq_pkg::TRIG_W-1:0];
                default:           led_reg       <= led_reg;
            endcase
        end
    end

    // Trigger match pulses, several channels may fire together
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            send_master_a <= 1'b0;
            send_master_b <= 1'b0;
            timer_start_a <= 1'b0;
            timer_start_b <= 1'b0;
        end else begin
            send_master_a <= wr_ev && xw_addr == cq_pkg::ADDR_TRIG && xw_data[3:0] == trigger_match_value_a;
            send_master_b <= wr_ev && xw_addr == cq_pkg::ADDR_TRIG && xw_data[3:0] == trigger_match_value_b;
            timer_start_a <= wr_ev && xw_addr == cq_pkg::ADDR_TRIG && xw_data[3:0] == trigger_match_value_a
                             && cycle_timer_on_a;
            timer_start_b <= wr_ev && xw_addr == cq_pkg::ADDR_TRIG && xw_data[3:0] == trigger_match_value_b
                             && cycle_timer_on_b;
        end
    end

    // Indication pins; interrupt masks are not consulted
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            error_led2_pin_a <= 1'b0;
            ready_led1_pin_a <= 1'b0;
        end else begin
            error_led2_pin_a <= led_reg[cq_pkg::LED_ERR_SEL_A] ? receive_error_flag_a
                                                               : led_reg[cq_pkg::LED_LED2_A];
            ready_led1_pin_a <= led_reg[cq_pkg::LED_RDY_SEL_A] ? receive_data_ready_flag_a
                                                               : led_reg[cq_pkg::LED_LED1_A];
        end
    end

    // Line driver modes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            line_pin_a_out  <= 1'b0;
            line_pin_a_oe_b <= 1'b1;
        end else if (cfg_reg[cq_pkg::CFG_DRV_OFF]) begin
            line_pin_a_out  <= 1'b0;
            line_pin_a_oe_b <= 1'b1;
        end else if (cfg_reg[cq_pkg::CFG_PP]) begin
            line_pin_a_out  <= tx_data_a;
            line_pin_a_oe_b <= 1'b0;
        end else begin
            line_pin_a_out  <= ~cfg_reg[cq_pkg::CFG_NPN];
            line_pin_a_oe_b <= ~tx_data_a;
        end
    end

    // Analog receiver and current element controls
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            current_on_a <= 1'b0;
        end else begin
            current_on_a <= cfg_reg[cq_pkg::CFG_LVL_LO +: 2] != cq_pkg::LVL_OFF;
        end
    end
    assign threshold_type_select_a    = cfg_reg[cq_pkg::CFG_THR];
    assign current_direction_select_a = cfg_reg[cq_pkg::CFG_DIR];
    assign current_level_select_a     = cfg_reg[cq_pkg::CFG_LVL_LO +: 2];
    assign receiver_burst_filter_on_a = cfg_reg[cq_pkg::CFG_FILT];

    // Line input synchroniser
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            line_s1 <= 1'b0;
            line_s2 <= 1'b0;
        end else begin
            line_s1 <= line_pin_a_in;
            line_s2 <= line_s1;
        end
    end

    // Burst filter: a new level must hold for the filter time
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_data_a <= 1'b0;
            filt_cnt  <= 9'h000;
        end else if (!cfg_reg[cq_pkg::CFG_FILT] || line_s2 == rx_data_a) begin
            rx_data_a <= line_s2;
            filt_cnt  <= 9'h000;
        end else if (filt_cnt == 9'(cq_pkg::FILT_CYC - 1)) begin
            rx_data_a <= line_s2;
            filt_cnt  <= 9'h000;
        end else begin
            filt_cnt <= filt_cnt + 9'h001;
        end
    end

    // Checks on the core clock
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_trig_wr;
        wr_ev && xw_addr == cq_pkg::ADDR_TRIG;
    endsequence

    chk_err_follow: assert property (led_reg[cq_pkg::LED_ERR_SEL_A] |=>
        error_led2_pin_a == $past(receive_error_flag_a)) else $error("error pin not following flag");
    chk_led2_drive: assert property (!led_reg[cq_pkg::LED_ERR_SEL_A] |=>
        error_led2_pin_a == $past(led_reg[cq_pkg::LED_LED2_A])) else $error("led2 wrong");
    chk_rdy_follow: assert property (led_reg[cq_pkg::LED_RDY_SEL_A] |=>
        ready_led1_pin_a == $past(receive_data_ready_flag_a)) else $error("ready pin not following flag");
    chk_led1_drive: assert property (!led_reg[cq_pkg::LED_RDY_SEL_A] |=>
        ready_led1_pin_a == $past(led_reg[cq_pkg::LED_LED1_A])) else $error("led1 wrong");
    chk_trig_send: assert property (s_trig_wr ##0 (xw_data[3:0] == trigger_match_value_a) |=>
        send_master_a) else $error("no send on match");
    chk_trig_store: assert property (s_trig_wr |=>
        (trigger_value == $past(xw_data[3:0])) ##1 !send_master_a)
        else $error("trigger store or pulse wrong");
    chk_timer_gate: assert property (timer_start_a |-> send_master_a && $past(cycle_timer_on_a))
        else $error("timer started while disabled");
    chk_cfg_hold: assert property (!wr_ev |=> $stable(cfg_reg)) else $error("config changed without write");
    chk_drv_off: assert property (cfg_reg[cq_pkg::CFG_DRV_OFF] |=> line_pin_a_oe_b)
        else $error("driver not off");
    chk_push_pull: assert property (cfg_reg[cq_pkg::CFG_PP] && !cfg_reg[cq_pkg::CFG_DRV_OFF] |=>
        !line_pin_a_oe_b && line_pin_a_out == $past(tx_data_a)) else $error("push-pull wrong");

    // Trigger writes pass whatever the select bits
    chk_trig_global: assert property (@(posedge spi_sclk) disable iff (!rst_b)
        !spi_cs_b && bit_cnt == cq_pkg::CNT_LAST && !next_word[15] && next_word[12:8] == cq_pkg::ADDR_TRIG
        |=> xw_tgl != $past(xw_tgl)) else $error("trigger write dropped");
endmodule : cq_chan_cfg

// ---- sim/cq_host_model.sv ----
`timescale 1ns/1ps
module cq_host_model (
    // Serial lines driven by the host
    output logic      spi_sclk,
    output logic      spi_cs_b,
    output logic      spi_mosi,
    // Read data from the device
    input  wire logic spi_miso
);
    // Idle bus: clock parked low, frame deselected
    initial begin
        spi_sclk = 1'h0;
        spi_cs_b = 1'h1;
        spi_mosi = 1'h0;
    end

    // One frame: command byte, data byte, 15 ns serial period
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] data, output logic [7:0] rd);
        logic [15:0] sh;
        sh = {cmd, data};
        spi_cs_b = 1'h0;
        for (int i = 15; i >= 0; i--) begin
            spi_mosi = sh[i];
            #7.5 spi_sclk = 1'h1;
            if (i < 8)
                rd[i] = spi_miso;
            #7.5 spi_sclk = 1'h0;
        end
        #7.5 spi_cs_b = 1'h1;
        spi_mosi = ~sh[0]; // Released line shows no stale value
        #15;
    endtask : xfer
endmodule : cq_host_model

// ---- sim/tb.sv ----
`timescale 1ns/1ps
module tb;
    typedef struct packed {logic [7:0] led; logic [7:0] cfg; logic [2:0] in; logic [3:0] ex;} cq_row_t;
    logic       clk = 1'h0, rst_b;
    logic [1:0] dev_addr = 2'h2;
    logic       receive_error_flag_a, receive_data_ready_flag_a, tx_data_a, line_pin_a_in;
    logic       cycle_timer_on_a, cycle_timer_on_b;
    logic [3:0] trigger_match_value_a, trigger_match_value_b, trigger_value;
    logic       spi_sclk, spi_cs_b, spi_mosi, spi_miso;
    logic       send_master_a, send_master_b, timer_start_a, timer_start_b, rx_data_a;
    logic       error_led2_pin_a, ready_led1_pin_a, line_pin_a_out, line_pin_a_oe_b;
    logic       threshold_type_select_a, current_direction_select_a, current_on_a, receiver_burst_filter_on_a;
    logic [1:0] current_level_select_a;
    logic [7:0] v, c;
    int         miscompares = 0, total_checks = 0, cycles = 0;
    int         n [4] = '{0, 0, 0, 0};
    int         n0 [4];
    // Rows: LED reg, line cfg, {err, rdy, tx}, expected {err pin, rdy pin, oe_b, line out}
    cq_row_t rows [10] = '{'{8'h00, 8'h04, 3'h7, 4'h1}, '{8'h0a, 8'h0c, 3'h0, 4'hc}, '{8'h05, 8'h08, 3'h5, 4'h8},
        '{8'h05, 8'h08, 3'h2, 4'h6}, '{8'h0f, 8'h00, 3'h1, 4'h1}, '{8'h08, 8'h00, 3'h6, 4'ha},
        '{8'h02, 8'h06, 3'h1, 4'h6}, '{8'h00, 8'hb1, 3'h1, 4'h1}, '{8'h00, 8'h52, 3'h1, 4'h2},
        '{8'h00, 8'h64, 3'h0, 4'h0}};
    wire logic [3:0] pulses = {send_master_a, send_master_b, timer_start_a, timer_start_b};

    always #2 clk = ~clk;

    cq_host_model cq_host_model_i (.spi_sclk, .spi_cs_b, .spi_mosi, .spi_miso);

    cq_chan_cfg cq_chan_cfg_i (.clk, .rst_b, .spi_sclk, .spi_cs_b, .spi_mosi, .spi_miso, .dev_addr,
        .receive_error_flag_a, .receive_data_ready_flag_a, .tx_data_a, .trigger_match_value_a,
        .trigger_match_value_b, .cycle_timer_on_a, .cycle_timer_on_b, .trigger_value, .send_master_a,
        .send_master_b, .timer_start_a, .timer_start_b, .rx_data_a, .error_led2_pin_a, .ready_led1_pin_a,
        .line_pin_a_in, .line_pin_a_out, .line_pin_a_oe_b, .threshold_type_select_a,
        .current_direction_select_a, .current_level_select_a, .current_on_a, .receiver_burst_filter_on_a);

    // Pulse counters and hang guard
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++)
            if (pulses[i] === 1'h1)
                n[i]++;
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [1:0] sel, input logic [4:0] a, input logic [7:0] d);
        logic [7:0] r;
        cq_host_model_i.xfer({1'h0, sel, a}, d, r);
        repeat (6) @(posedge clk);
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        cq_host_model_i.xfer({1'h1, dev_addr, a}, 8'h00, d);
        @(posedge clk);
    endtask : rd

    task automatic conclude();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    // Main sequence
    initial begin
        rst_b <= 1'h0; // Falling edge after all processes wait, so async resets fire
        {receive_error_flag_a, receive_data_ready_flag_a, tx_data_a, line_pin_a_in} = 4'h0;
        {cycle_timer_on_a, cycle_timer_on_b} = 2'h0;
        trigger_match_value_a = 4'h0;
        trigger_match_value_b = 4'h0;
        repeat (6) @(posedge clk);
        rst_b <= 1'h1;
        repeat (4) @(posedge clk);
        chk({1'h0, error_led2_pin_a, ready_led1_pin_a, line_pin_a_oe_b, trigger_value}, 8'h10, "reset");
        rd(cq_pkg::ADDR_CFG, v);
        chk(v, cq_pkg::RST_CFG, "cfg reset");
        // Table of pin and line settings
        foreach (rows[i]) begin
            wr(dev_addr, cq_pkg::ADDR_LED, rows[i].led);
            wr(dev_addr, cq_pkg::ADDR_CFG, rows[i].cfg);
            {receive_error_flag_a, receive_data_ready_flag_a, tx_data_a} <= rows[i].in;
            repeat (6) @(posedge clk);
            c = rows[i].cfg;
            chk({5'h00, error_led2_pin_a, ready_led1_pin_a, line_pin_a_oe_b},
                {5'h00, rows[i].ex[3:1]}, "pins");
            if (!rows[i].ex[1])
                chk({7'h00, line_pin_a_out}, {7'h00, rows[i].ex[0]}, "line");
            chk({2'h0, threshold_type_select_a, current_direction_select_a, current_level_select_a,
                receiver_burst_filter_on_a, current_on_a}, {2'h0, c[7:4], c[0], |c[5:4]}, "analog");
            rd(cq_pkg::ADDR_CFG, v);
            chk(v, c, "cfg read");
            rd(cq_pkg::ADDR_LED, v);
            chk(v, rows[i].led, "led read");
        end
        // Broadcast trigger, unselected address, upper bits set
        trigger_match_value_a <= 4'h5;
        trigger_match_value_b <= 4'h5;
        cycle_timer_on_a <= 1'h1;
        @(posedge clk);
        n0 = n;
        wr(~dev_addr, cq_pkg::ADDR_TRIG, 8'hf5);
        chk({4'h0, trigger_value}, 8'h05, "trigger");
        chk({2'(n[3] - n0[3]), 2'(n[2] - n0[2]), 2'(n[1] - n0[1]), 2'(n[0] - n0[0])}, 8'h54, "start a");
        trigger_match_value_b <= 4'h3;
        cycle_timer_on_b <= 1'h1;
        @(posedge clk);
        n0 = n;
        wr(dev_addr, cq_pkg::ADDR_TRIG, 8'h03);
        chk({2'(n[3] - n0[3]), 2'(n[2] - n0[2]), 2'(n[1] - n0[1]), 2'(n[0] - n0[0])}, 8'h11, "start b");
        rd(cq_pkg::ADDR_TRIG, v);
        chk(v, 8'h00, "trigger read");
        // Unselected write ignored, reads do not clear
        wr(~dev_addr, cq_pkg::ADDR_CFG, 8'hff);
        rd(cq_pkg::ADDR_CFG, v);
        chk(v, 8'h64, "unselected");
        rd(cq_pkg::ADDR_CFG, v);
        chk(v, 8'h64, "reread");
        // Burst filter: short pulse dropped, long level passed
        wr(dev_addr, cq_pkg::ADDR_CFG, 8'h01);
        line_pin_a_in <= 1'h1;
        repeat (100) @(posedge clk);
        chk({7'h00, rx_data_a}, 8'h00, "burst");
        line_pin_a_in <= 1'h0;
        repeat (345) @(posedge clk);
        chk({7'h00, rx_data_a}, 8'h00, "burst end");
        line_pin_a_in <= 1'h1;
        repeat (345) @(posedge clk);
        chk({7'h00, rx_data_a}, 8'h01, "long level");
        wr(dev_addr, cq_pkg::ADDR_CFG, 8'h00);
        line_pin_a_in <= 1'h0;
        repeat (8) @(posedge clk);
        chk({7'h00, rx_data_a}, 8'h00, "unfiltered");
        // Reset again in mid-run: stored trigger returns to zero
        rst_b <= 1'h0;
        repeat (6) @(posedge clk);
        chk({4'h0, trigger_value}, 8'h00, "mid reset");
        rst_b <= 1'h1;
        repeat (4) @(posedge clk);
        rd(cq_pkg::ADDR_CFG, v);
        chk(v, cq_pkg::RST_CFG, "cfg after reset");
        conclude();
    end
endmodule : tb
